/* File: dv/mlsc_host_model.sv */
// Host board model: serial bus master with open-drain data drive
`timescale 1ns/1ps

module mlsc_host_model (
  // Serial clock and data as the host drives them
  output logic scl_clk,
  output logic sda_drv,
  // Resolved data wire level
  input wire logic sda
);
  // Bus idles high; the clock stands still between frames
  initial begin
    scl_clk = 1'b1;
    sda_drv = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One bit out: data moves mid low phase, never while the clock is high
  task automatic bit_out(input logic b);
    scl_clk = 1'b0;
    #3 sda_drv = b;
    #3 scl_clk = 1'b1;
    #6;
  endtask

  // One bit in: data released so the target can pull, sampled after the rise
  task automatic bit_in(output logic b);
    scl_clk = 1'b0;
    #3 sda_drv = 1'b1;
    #3 scl_clk = 1'b1;
    #1 b = sda;
    #5;
  endtask

  // Start; a repeated start first lets the wire rise while the clock is low, then raises the clock
  task automatic start_cond();
    if (!(sda_drv && sda)) begin
      bit_out(1'b1);
    end
    sda_drv = 1'b0;
    #6;
  endtask

  // Stop: data rises while the clock is high
  task automatic stop_cond();
    bit_out(1'b0);
    sda_drv = 1'b1;
    #6;
  endtask

  // Byte out, most significant bit first, then the target's acknowledge
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(a);
    ack = !a;
  endtask

  // Byte in; the host acknowledges to continue or not to end the read
  task automatic byte_in(input logic ack_it, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bit_in(d[i]);
    end
    bit_out(!ack_it);
  endtask
endmodule

/* File: dv/test_module_low_speed_control.sv */
// Self-checking bench for the module low-speed control block
`timescale 1ns/1ps
`include "mlsc_map.svh"

module test_module_low_speed_control;
  import mlsc_pkg::*;
  localparam int INIT = 50;
  logic ref_clk, arst_n, module_select_n, module_reset_n, low_power_select;
  logic scl_clk, host_sda, sda_o, sda_oe_n, module_present_n, pulled;
  logic module_interrupt_n_o, module_interrupt_n_oe_n, high_power_en;
  int failures, checked;
  // Open-drain wires resolved with host pull-ups
  wire sda = host_sda & (sda_oe_n | sda_o);
  wire int_wire = module_interrupt_n_oe_n | module_interrupt_n_o;

  mlsc_module_ctrl #(.INIT_CYC(INIT)) mlsc_module_ctrl_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .scl_clk(scl_clk), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .module_select_n(module_select_n),
    .module_reset_n(module_reset_n), .low_power_select(low_power_select),
    .module_present_n(module_present_n), .module_interrupt_n_o(module_interrupt_n_o),
    .module_interrupt_n_oe_n(module_interrupt_n_oe_n), .high_power_en(high_power_en));

  mlsc_host_model mlsc_host_model_i (.scl_clk(scl_clk), .sda_drv(host_sda), .sda(sda));

  // Reference clock, 50 ns
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Flags any data pull seen while the host has the module deselected
  always @(posedge scl_clk) begin
    if (module_select_n === 1'b1 && sda_oe_n === 1'b0) pulled = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Inputs always move the same small delay after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Bounded wait for the interrupt wire to go low
  task automatic wait_int(input int lim, output logic ok);
    int n;
    n = 0;
    while (int_wire !== 1'b0 && n < lim) begin
      tick(1);
      n++;
    end
    ok = (int_wire === 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Write two bytes from a pointer
  task automatic ser_wr(input logic [6:0] ptr, input logic [15:0] d, output logic ok);
    logic a0, a1, a2, a3;
    mlsc_host_model_i.start_cond();
    mlsc_host_model_i.byte_out({`MLSC_TWI_ADDR, 1'b0}, a0);
    mlsc_host_model_i.byte_out({1'b0, ptr}, a1);
    mlsc_host_model_i.byte_out(d[15:8], a2);
    mlsc_host_model_i.byte_out(d[7:0], a3);
    mlsc_host_model_i.stop_cond();
    ok = a0 & a1 & a2 & a3;
  endtask

  // Set the pointer, repeated start, read two bytes (ack then no ack)
  task automatic ser_rd(input logic [6:0] ptr, output logic [15:0] d, output logic ok);
    logic a0, a1, a2;
    mlsc_host_model_i.start_cond();
    mlsc_host_model_i.byte_out({`MLSC_TWI_ADDR, 1'b0}, a0);
    mlsc_host_model_i.byte_out({1'b0, ptr}, a1);
    mlsc_host_model_i.start_cond();
    mlsc_host_model_i.byte_out({`MLSC_TWI_ADDR, 1'b1}, a2);
    mlsc_host_model_i.byte_in(1'b1, d[15:8]);
    mlsc_host_model_i.byte_in(1'b0, d[7:0]);
    mlsc_host_model_i.stop_cond();
    ok = a0 & a1 & a2;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Power-up: completion interrupt on its own, status read clears it
  task automatic t_power_up();
    logic ok;
    logic [15:0] d;
    chk_bit(int_wire, 1'b1);
    chk_bit(module_present_n, 1'b0);
    chk_bit(high_power_en, 1'b0);
    wait_int(INIT + 20, ok);
    chk_bit(ok, 1'b1);
    chk_bit(module_interrupt_n_o, 1'b0);
    chk_bit(sda_o, 1'b0);
    ser_rd(`MLSC_DNR_BYTE, d, ok);
    chk_bit(ok, 1'b1);
    chk_bit(d[8 + `MLSC_DNR_BIT], 1'b0);
    chk_bit(d[`MLSC_IRQ_BIT], 1'b1);
    tick(10);
    chk_bit(int_wire, 1'b1);
  endtask

  // Memory write and read back, including the pointer wrap at the top
  task automatic t_mem();
    logic ok;
    logic [15:0] d;
    logic [6:0] p[2] = '{7'h10, 7'h7F};
    logic [15:0] w[2] = '{16'hA53C, 16'h1122};
    for (int i = 0; i < 2; i++) begin
      ser_wr(p[i], w[i], ok);
      chk_bit(ok, 1'b1);
      ser_rd(p[i], d, ok);
      chk_data(d, w[i]);
    end
  endtask

  // Deselected: no acknowledge, no pull, memory untouched
  task automatic t_desel();
    logic ok;
    logic [15:0] d;
    module_select_n = 1'b1;
    tick(10);
    pulled = 1'b0;
    ser_wr(7'h10, 16'hFFFF, ok);
    chk_bit(ok, 1'b0);
    chk_bit(pulled, 1'b0);
    module_select_n = 1'b0;
    tick(10);
    ser_rd(7'h10, d, ok);
    chk_data(d, 16'hA53C);
  endtask

  // Short reset pulse ignored, long one clears all and posts completion
  task automatic t_reset();
    logic ok;
    logic [15:0] d;
    module_reset_n = 1'b0;
    tick(150);
    chk_bit(high_power_en, 1'b1);
    module_reset_n = 1'b1;
    tick(10);
    ser_rd(7'h10, d, ok);
    chk_data(d, 16'hA53C);
    module_reset_n = 1'b0;
    tick(260);
    chk_bit(high_power_en, 1'b0);
    chk_bit(int_wire, 1'b1);
    module_reset_n = 1'b1;
    tick(1);
    // Memory is not read back until the completion interrupt shows
    wait_int(INIT + 40, ok);
    chk_bit(ok, 1'b1);
    ser_rd(7'h10, d, ok);
    chk_data(d, {2{`MLSC_MEM_RST}});
  endtask

  // Power limit follows the low-power input
  task automatic t_lowpower();
    tick(6);
    chk_bit(high_power_en, 1'b1);
    low_power_select = 1'b1;
    tick(6);
    chk_bit(high_power_en, 1'b0);
    low_power_select = 1'b0;
    tick(6);
    chk_bit(high_power_en, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; this module has its own select line only
  initial begin
    failures = 0;
    checked = 0;
    pulled = 1'b0;
    arst_n = 1'b0;
    module_select_n = 1'b0;
    module_reset_n = 1'b1;
    low_power_select = 1'b0;
    tick(12);
    arst_n = 1'b1;
    tick(2);
    t_power_up();
    t_mem();
    t_desel();
    t_reset();
    t_lowpower();
    print_verdict();
  end

  // Watchdog, well past the expected run of some tens of microseconds
  initial begin
    #1000000;
    failures++;
    print_verdict();
  end
endmodule

/* File: rtl/mlsc_map.svh */
// Constants for the module low-speed control block: offsets, fields, reset values, timing
`ifndef MLSC_MAP_SVH
`define MLSC_MAP_SVH

// Reference clock period, 20 MHz
`define MLSC_CLK_PERIOD_NS 50
// Longest power-on initialisation time
`define MLSC_INIT_TIME_MS 2000
// Init count rounds down, being a longest time
`define MLSC_INIT_CYC ((64'(`MLSC_INIT_TIME_MS) * 64'd1000000) / 64'(`MLSC_CLK_PERIOD_NS))
// Least reset pulse length
`define MLSC_RST_MIN_NS 10000
// Least time rounds up to whole cycles
`define MLSC_RST_MIN_CYC ((`MLSC_RST_MIN_NS + `MLSC_CLK_PERIOD_NS - 1) / `MLSC_CLK_PERIOD_NS)
// Counter widths
`define MLSC_INIT_CW 26
`define MLSC_RST_CW 16

// Serial bus target address
`define MLSC_TWI_ADDR 7'h50
// Memory map: byte pointer width, entry reset value
`define MLSC_MEM_AW 7
`define MLSC_MEM_RST 8'h00
// Status bytes of the memory map
`define MLSC_DNR_BYTE 7'h02
`define MLSC_DNR_BIT 0
`define MLSC_IRQ_BYTE 7'h03
`define MLSC_IRQ_BIT 0

// Pin synchroniser order {clear toggle, select, reset, low power} and reset levels
`define MLSC_SY_LP 0
`define MLSC_SY_RST 1
`define MLSC_SY_SEL 2
`define MLSC_SY_CLR 3
`define MLSC_SY_RSTVAL 4'h7

`endif

/* File: rtl/mlsc_module_ctrl.sv */
// Module low-speed control: pin filters, reset sequencer, interrupt, power limit
`timescale 1ns/1ps
`include "mlsc_map.svh"


module mlsc_module_ctrl
  import mlsc_pkg::*;
#(
  parameter int unsigned INIT_CYC = int'(`MLSC_INIT_CYC)
) (
  // Reference clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Serial bus, link clock domain
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Control inputs from the host
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic low_power_select,
  // Status outputs to the host
  output logic module_present_n,
  output logic module_interrupt_n_o,
  output logic module_interrupt_n_oe_n,
  // Power stage enable
  output logic high_power_en
);

  localparam logic [`MLSC_RST_CW-1:0] RST_MIN_CYC = `MLSC_RST_CW'(`MLSC_RST_MIN_CYC);
  localparam logic [`MLSC_INIT_CW-1:0] INIT_LAST = `MLSC_INIT_CW'(INIT_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Three-flop filters; a level counts once stages two and three agree
  logic [3:0] in_vec, sy1_reg, sy2_reg, sy3_reg, acc_reg;
  logic [3:0] sy1_next, sy2_next, sy3_next, acc_next;
  logic irq_clr_tog, clr_evt;

  assign in_vec = {irq_clr_tog, module_select_n, module_reset_n, low_power_select};

  always_comb begin
    sy1_next = in_vec;
    sy2_next = sy1_reg;
    sy3_next = sy2_reg;
  end

  for (genvar g = 0; g < 4; g++) begin : g_filt
    assign acc_next[g] = (sy2_reg[g] == sy3_reg[g]) ? sy3_reg[g] : acc_reg[g];
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sy1_reg <= `MLSC_SY_RSTVAL;
      sy2_reg <= `MLSC_SY_RSTVAL;
      sy3_reg <= `MLSC_SY_RSTVAL;
      acc_reg <= `MLSC_SY_RSTVAL;
    end else begin
      sy1_reg <= sy1_next;
      sy2_reg <= sy2_next;
      sy3_reg <= sy3_next;
      acc_reg <= acc_next;
    end
  end

  // Each change of the link toggle is one read of the interrupt byte
  assign clr_evt = acc_next[`MLSC_SY_CLR] ^ acc_reg[`MLSC_SY_CLR];

  ////////////////////////////////////////////////////////////////////////////
  // Reset and initialisation sequencer
  mlsc_seq_t seq_reg, seq_next;
  logic [`MLSC_RST_CW-1:0] rst_cnt_reg, rst_cnt_next;
  logic [`MLSC_INIT_CW-1:0] init_cnt_reg, init_cnt_next;
  logic rst_low;

  assign rst_low = !acc_reg[`MLSC_SY_RST];

  // Short glitches on the reset pin are ignored; only a long pulse resets
  always_comb begin
    seq_next = seq_reg;
    init_cnt_next = init_cnt_reg;
    rst_cnt_next = '0;
    if (rst_low) begin
      rst_cnt_next = (rst_cnt_reg == RST_MIN_CYC) ? rst_cnt_reg : rst_cnt_reg + 1'b1;
    end
    unique case (seq_reg)
      SEQ_RESET: begin
        init_cnt_next = '0;
        if (!rst_low) seq_next = SEQ_INIT;
      end
      SEQ_INIT: begin
        init_cnt_next = init_cnt_reg + 1'b1;
        if (init_cnt_reg == INIT_LAST) seq_next = SEQ_READY;
      end
      SEQ_READY: ;
      default: seq_next = SEQ_RESET;
    endcase
    if (rst_low && rst_cnt_reg == RST_MIN_CYC) begin
      seq_next = SEQ_RESET;
    end
  end

  // Power-up starts straight in initialisation, no reset pulse needed
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_reg <= SEQ_INIT;
      rst_cnt_reg <= '0;
      init_cnt_reg <= '0;
    end else begin
      seq_reg <= seq_next;
      rst_cnt_reg <= rst_cnt_next;
      init_cnt_reg <= init_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags, link reset and power limit
  logic dnr_reg, dnr_next, int_flag_reg, int_flag_next, clr_mem_reg, clr_mem_next;
  logic hp_reg, hp_next, ready_set, twi_rst_n;

  assign ready_set = (seq_reg == SEQ_INIT) && (seq_next == SEQ_READY);

  // Set wins over a clear landing in the same cycle
  always_comb begin
    dnr_next = (seq_next != SEQ_READY);
    int_flag_next = int_flag_reg;
    if (clr_evt) int_flag_next = 1'b0;
    if (seq_next == SEQ_RESET) int_flag_next = 1'b0;
    if (ready_set) int_flag_next = 1'b1;
    clr_mem_next = (seq_next == SEQ_RESET);
    hp_next = !acc_reg[`MLSC_SY_LP] && (seq_reg == SEQ_READY);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dnr_reg <= 1'b1;
      int_flag_reg <= 1'b0;
      clr_mem_reg <= 1'b0;
      hp_reg <= 1'b0;
    end else begin
      dnr_reg <= dnr_next;
      int_flag_reg <= int_flag_next;
      clr_mem_reg <= clr_mem_next;
      hp_reg <= hp_next;
    end
  end

  // Memory map cleared asynchronously, since the link clock may stand still
  assign twi_rst_n = arst_n & ~clr_mem_reg;

  // Open-drain interrupt and grounded presence line
  assign module_interrupt_n_o = 1'b0;
  assign module_interrupt_n_oe_n = ~int_flag_reg;
  assign module_present_n = 1'b0;
  assign high_power_en = hp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Serial target on the link clock
  mlsc_twi_target mlsc_twi_target_i (
    .scl_clk(scl_clk),
    .rst_n(twi_rst_n),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_n(sda_oe_n),
    .sel_n(acc_reg[`MLSC_SY_SEL]),
    .dnr(dnr_reg),
    .irq(int_flag_reg),
    .irq_clr_tog(irq_clr_tog)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the reference side
  default clocking cb_ref @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_long_low;
    rst_low && rst_cnt_reg == RST_MIN_CYC;
  endsequence

  sequence s_ready_entry;
    seq_reg == SEQ_INIT && init_cnt_reg == INIT_LAST && !rst_low;
  endsequence

  a_reset_long: assert property (s_long_low |=> (seq_reg == SEQ_RESET && !twi_rst_n))
    else $error("long reset pulse did not clear the block");
  a_reset_short: assert property ((seq_reg == SEQ_READY && !rst_low) ##1
      (rst_low && rst_cnt_reg < RST_MIN_CYC - 1'b1) |=> seq_reg == SEQ_READY)
    else $error("short reset pulse disturbed the block");
  a_ready_irq: assert property (s_ready_entry |=>
      (seq_reg == SEQ_READY && !dnr_reg && !module_interrupt_n_oe_n))
    else $error("completion interrupt missing or not-ready flag still set");
  a_powerup_irq: assert property ((seq_reg == SEQ_INIT && $past(seq_reg) == SEQ_INIT
      && init_cnt_reg == INIT_LAST && !rst_low) ##1 1'b1 |-> int_flag_reg)
    else $error("no completion interrupt after initialisation");
  a_irq_cause: assert property (!module_interrupt_n_oe_n |-> (seq_reg == SEQ_READY
      && !dnr_reg))
    else $error("interrupt pulled low outside the ready state");
  a_irq_release: assert property ($rose(module_interrupt_n_oe_n) |->
      ($past(clr_evt) || $past(seq_next) == SEQ_RESET))
    else $error("interrupt released without a clear");
  a_power_limit: assert property (acc_reg[`MLSC_SY_LP] |=> !high_power_en)
    else $error("high power enabled while low power is selected");

endmodule

/* File: rtl/mlsc_pkg.sv */
// Types shared by the module low-speed control block
package mlsc_pkg;

  // Reset and initialisation sequencer
  typedef enum logic [1:0] {
    SEQ_RESET = 2'b00,
    SEQ_INIT = 2'b01,
    SEQ_READY = 2'b10
  } mlsc_seq_t;

  // Serial bus target states
  typedef enum logic [2:0] {
    TW_IDLE = 3'b000,
    TW_ADDR = 3'b001,
    TW_PTR = 3'b010,
    TW_WDATA = 3'b011,
    TW_RDATA = 3'b100
  } mlsc_twi_st_t;

endpackage

/* File: rtl/mlsc_twi_target.sv */
// Two-wire serial target with memory map, clocked by the serial clock
`timescale 1ns/1ps
`include "mlsc_map.svh"

module mlsc_twi_target
  import mlsc_pkg::*;
(
  // Link clock and reset
  input wire logic scl_clk,
  input wire logic rst_n,
  // Serial data pin
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Levels from the reference domain
  input wire logic sel_n,
  input wire logic dnr,
  input wire logic irq,
  // Interrupt byte read event, as a toggle
  output logic irq_clr_tog
);

  ////////////////////////////////////////////////////////////////////////////
  // Start and stop detection on data edges while the clock is high
  logic start_tog_reg, start_tog_next, stop_tog_reg, stop_tog_next;

  always_comb begin
    start_tog_next = scl_clk ? ~start_tog_reg : start_tog_reg;
    stop_tog_next = scl_clk ? ~stop_tog_reg : stop_tog_reg;
  end

  always_ff @(negedge sda_i or negedge rst_n) begin
    if (!rst_n) start_tog_reg <= 1'b0;
    else start_tog_reg <= start_tog_next;
  end

  always_ff @(posedge sda_i or negedge rst_n) begin
    if (!rst_n) stop_tog_reg <= 1'b0;
    else stop_tog_reg <= stop_tog_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Three-flop filters for {select, not ready, interrupt}; a level counts
  // once stages two and three agree, so a metastable sample is never used
  logic [2:0] sy1_reg, sy2_reg, sy3_reg, acc_reg, sy1_next, sy2_next, sy3_next, acc_next;
  logic sel_ok;

  always_comb begin
    sy1_next = {sel_n, dnr, irq};
    sy2_next = sy1_reg;
    sy3_next = sy2_reg;
    acc_next = (sy3_reg & ~(sy2_reg ^ sy3_reg)) | (acc_reg & (sy2_reg ^ sy3_reg));
  end

  always_ff @(posedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      sy1_reg <= 3'h4;
      sy2_reg <= 3'h4;
      sy3_reg <= 3'h4;
      acc_reg <= 3'h4;
    end else begin
      sy1_reg <= sy1_next;
      sy2_reg <= sy2_next;
      sy3_reg <= sy3_next;
      acc_reg <= acc_next;
    end
  end

  // Select settles by the fourth clock rise of a frame, well before the address slot
  assign sel_ok = !acc_reg[2];

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine
  mlsc_twi_st_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next, rbuf_reg, rbuf_next;
  logic [`MLSC_MEM_AW-1:0] ptr_reg, ptr_next;
  logic start_ack_reg, start_ack_next, stop_ack_reg, stop_ack_next;
  logic clr_tog_reg, clr_tog_next;
  logic wr_en;
  logic [7:0] mem_reg [2**`MLSC_MEM_AW];
  logic [7:0] mem_next [2**`MLSC_MEM_AW];

  // Status bytes are live views; others come from storage
  function automatic logic [7:0] rd_byte(input logic [`MLSC_MEM_AW-1:0] a);
    logic [7:0] b;
    b = mem_reg[a];
    if (a == `MLSC_DNR_BYTE) begin
      b = 8'h00;
      b[`MLSC_DNR_BIT] = acc_reg[1];
    end else if (a == `MLSC_IRQ_BYTE) begin
      b = 8'h00;
      b[`MLSC_IRQ_BIT] = acc_reg[0];
    end
    return b;
  endfunction

  // Each clock rise: start wins, then stop, then bit or acknowledge slot
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    rbuf_next = rbuf_reg;
    ptr_next = ptr_reg;
    start_ack_next = start_ack_reg;
    stop_ack_next = stop_ack_reg;
    clr_tog_next = clr_tog_reg;
    wr_en = 1'b0;
    if (start_tog_reg != start_ack_reg) begin
      state_next = TW_ADDR;
      cnt_next = 4'h1;
      shift_next = {7'h00, sda_i};
      start_ack_next = start_tog_reg;
      stop_ack_next = stop_tog_reg;
    end else if (state_reg == TW_IDLE || stop_tog_reg != stop_ack_reg) begin
      state_next = TW_IDLE;
      stop_ack_next = stop_tog_reg;
    end else if (cnt_reg == 4'h8) begin
      cnt_next = 4'h0;
      unique case (state_reg)
        TW_ADDR: begin
          // Answer only our address and only while selected
          if (shift_reg[7:1] != `MLSC_TWI_ADDR || !sel_ok) begin
            state_next = TW_IDLE;
          end else if (shift_reg[0]) begin
            state_next = TW_RDATA;
            rbuf_next = rd_byte(ptr_reg);
            ptr_next = ptr_reg + 1'b1;
            if (ptr_reg == `MLSC_IRQ_BYTE) clr_tog_next = ~clr_tog_reg;
          end else begin
            state_next = TW_PTR;
          end
        end
        TW_PTR: begin
          ptr_next = shift_reg[`MLSC_MEM_AW-1:0];
          state_next = TW_WDATA;
        end
        TW_WDATA: begin
          wr_en = 1'b1;
          ptr_next = ptr_reg + 1'b1;
        end
        TW_RDATA: begin
          // Host not-acknowledge ends the read
          if (sda_i) begin
            state_next = TW_IDLE;
          end else begin
            rbuf_next = rd_byte(ptr_reg);
            ptr_next = ptr_reg + 1'b1;
            if (ptr_reg == `MLSC_IRQ_BYTE) clr_tog_next = ~clr_tog_reg;
          end
        end
        default: state_next = TW_IDLE;
      endcase
    end else begin
      shift_next = {shift_reg[6:0], sda_i};
      rbuf_next = {rbuf_reg[6:0], 1'b1};
      cnt_next = cnt_reg + 4'h1;
    end
  end

  // One write port; a complete reset returns every entry to default
  for (genvar i = 0; i < 2**`MLSC_MEM_AW; i++) begin : g_mem
    assign mem_next[i] = (wr_en && ptr_reg == i) ? shift_reg : mem_reg[i];
    always_ff @(posedge scl_clk or negedge rst_n) begin
      if (!rst_n) mem_reg[i] <= `MLSC_MEM_RST;
      else mem_reg[i] <= mem_next[i];
    end
  end

  always_ff @(posedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= TW_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rbuf_reg <= 8'hFF;
      ptr_reg <= '0;
      start_ack_reg <= 1'b0;
      stop_ack_reg <= 1'b0;
      clr_tog_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      rbuf_reg <= rbuf_next;
      ptr_reg <= ptr_next;
      start_ack_reg <= start_ack_next;
      stop_ack_reg <= stop_ack_next;
      clr_tog_reg <= clr_tog_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data pin changes only while the clock is low; pull low or release only
  logic drv_low, oe_n_reg, oe_n_next;

  always_comb begin
    drv_low = sel_ok && ((cnt_reg == 4'h8 && ((state_reg == TW_ADDR
      && shift_reg[7:1] == `MLSC_TWI_ADDR) || state_reg == TW_PTR
      || state_reg == TW_WDATA)) || (state_reg == TW_RDATA && cnt_reg != 4'h8
      && !rbuf_reg[7]));
    oe_n_next = !drv_low;
  end

  always_ff @(negedge scl_clk or negedge rst_n) begin
    if (!rst_n) oe_n_reg <= 1'b1;
    else oe_n_reg <= oe_n_next;
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = oe_n_reg;
  assign irq_clr_tog = clr_tog_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the link side
  default clocking cb_scl @(posedge scl_clk); endclocking
  default disable iff (!rst_n);

  sequence s_addr_done;
    state_reg == TW_ADDR && cnt_reg == 4'h8 && start_tog_reg == start_ack_reg;
  endsequence

  a_unsel_quiet: assert property (!oe_n_reg |-> sel_ok)
    else $error("data pin pulled low while not selected");
  a_addr_ack: assert property (s_addr_done |->
      (!oe_n_reg == (shift_reg[7:1] == `MLSC_TWI_ADDR && sel_ok)))
    else $error("address acknowledge does not match address and select");
  a_read_bit: assert property ((state_reg == TW_RDATA && cnt_reg != 4'h8 && sel_ok
      && start_tog_reg == start_ack_reg) |-> (oe_n_reg == rbuf_reg[7]))
    else $error("read data bit on pin differs from shift buffer");

endmodule
